// *** common/gscr_pkg.sv ***
// Package of constants for the gas sensor configuration register block
package gscr_pkg;

   // ==========================================================
   // Holding register addresses
   localparam logic [15:0] ADDR_CAL_RESULT = 16'h0000;
   localparam logic [15:0] ADDR_COMMAND = 16'h0001;
   localparam logic [15:0] ADDR_BASE_PERIOD = 16'h000d;
   localparam logic [15:0] ADDR_CTRL_WORD = 16'h0012;
   localparam logic [15:0] ADDR_SCALE_NUM = 16'h0014;
   localparam logic [15:0] ADDR_SCALE_DEN = 16'h0015;
   localparam logic [15:0] ADDR_PRESSURE = 16'h002e;

   // ==========================================================
   // Control word fields
   localparam int CTRL_ABC_OFF_BIT = 1;
   localparam int CTRL_IIR_LO_BIT = 2;
   localparam int CTRL_IIR_HI_BIT = 3;
   localparam int CTRL_PCOMP_OFF_BIT = 4;

   // ==========================================================
   // Command and status codes
   localparam logic [15:0] CMD_ZERO_CAL = 16'h7c07;
   localparam logic [15:0] CAL_OK = 16'h0040;
   localparam logic [15:0] CAL_FAIL = 16'h0000;

   // ==========================================================
   // Values after reset
   localparam logic [15:0] RST_CAL_RESULT = 16'h0000;
   localparam logic [15:0] RST_COMMAND = 16'h0000;
   localparam logic [15:0] RST_BASE_PERIOD = 16'h0001;
   localparam logic [15:0] RST_CTRL_WORD = 16'h0000;
   localparam logic [15:0] RST_SCALE_NUM = 16'h0001;
   localparam logic [15:0] RST_SCALE_DEN = 16'h0001;
   localparam logic [15:0] RST_PRESSURE = 16'h0000;

   // ==========================================================
   // Pressure clamp, units of 0.1 hPa
   localparam logic [15:0] PRESS_MIN = 16'h0bb8;
   localparam logic [15:0] PRESS_MAX = 16'h32c8;

   // ==========================================================
   // Serial framing
   localparam logic [7:0] FC_READ_HOLD = 8'h03;
   localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
   localparam logic [7:0] FC_EXC_FLAG = 8'h80;
   localparam logic [7:0] EXC_BAD_FUNC = 8'h01;
   localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
   localparam logic [15:0] CRC_INIT = 16'hffff;
   localparam logic [15:0] CRC_POLY = 16'ha001;
   localparam logic [15:0] READ_MAX = 16'h007d;
   localparam logic [8:0] LEN_READ_REQ = 9'h008;
   localparam logic [8:0] LEN_WRITE_HDR = 9'h007;
   localparam logic [8:0] LEN_MIN = 9'h004;
   localparam logic [8:0] LEN_EXC_RSP = 9'h003;
   localparam logic [8:0] LEN_WRITE_RSP = 9'h006;

   typedef enum logic [1:0]
   {
      GSCR_ST_IDLE = 2'b00,
      GSCR_ST_APPLY = 2'b01,
      GSCR_ST_TX = 2'b11
   } gscr_state_t;

   typedef enum logic [1:0]
   {
      GSCR_RK_EXC = 2'b00,
      GSCR_RK_READ = 2'b01,
      GSCR_RK_WRITE = 2'b10
   } gscr_resp_t;

endpackage

// *** logic/gscr_ram.sv ***
// Staging memory for write-multiple data words, registered read
module gscr_ram #(
   parameter int DW = 16,
   parameter int AW = 7
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [DW-1:0] wr_data,
   input wire logic [AW-1:0] rd_addr,
   output logic [DW-1:0] rd_data
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge ref_clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         rd_data <= '0;
      end
      else
      begin
         rd_data <= mem[rd_addr];
      end
   end
endmodule

// *** logic/gscr_top.sv ***
// Serial-framed configuration and command registers of a refrigerant gas sensor
// How it works
// - Control bit1 set turns baseline correction off
// - Control bit1 clear runs baseline correction
// - Zero baseline period also turns correction off
// - Bits 2,3 both zero enable dynamic filter
// - Bits 2,3 both one disable all filtering
// - Command 0x7C07 at 0x0001 starts zero calibration
// - Successful calibration reports 0x40 at 0x0000
// - Control bit4 clear enables pressure compensation
// - No compensation until pressure ever written
// - Pressure clamped into 3000..13000 before use
// - New pressure applies from next gas calculation
// - New scaling effective after sensor reset only
// - Write reply echoes address, function, start, count
module gscr_top #(
   parameter logic [7:0] DEV_ADDR = 8'h68,
   parameter int WR_MAX = 123,
   parameter int RAM_AW = 7
) (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [7:0] rx_byte,
   input wire logic rx_valid,
   input wire logic rx_frame_end,
   output logic [7:0] tx_byte,
   output logic tx_valid,
   input wire logic tx_ready,
   input wire logic meas_tick,
   input wire logic sensor_reset,
   input wire logic cal_done,
   input wire logic cal_ok,
   output logic zero_cal_start,
   output logic abc_en,
   output logic [15:0] abc_period,
   output logic iir_dyn_en,
   output logic iir_static_en,
   output logic pcomp_en,
   output logic [15:0] pcomp_pressure,
   output logic [15:0] scale_num,
   output logic [15:0] scale_den
);
   // ==========================================================
   // Declarations
   gscr_pkg::gscr_state_t st_q;
   gscr_pkg::gscr_resp_t kind_q;
   logic [8:0] rx_cnt_q;
   logic rx_ovf_q;
   logic [15:0] crc_rx_q;
   logic [7:0] addr_q;
   logic [7:0] func_q;
   logic [15:0] start_q;
   logic [15:0] count_q;
   logic [7:0] bc_q;
   logic [7:0] hi_byte_q;
   logic [7:0] exc_q;
   logic [8:0] plen_q;
   logic [8:0] tx_idx_q;
   logic [15:0] crc_tx_q;
   logic [7:0] tx_byte_q;
   logic tx_valid_q;
   logic [RAM_AW-1:0] ap_idx_q;
   logic [RAM_AW-1:0] ap_widx_q;
   logic ap_vld_q;
   logic ap_issue_done_q;
   logic [15:0] ram_rdata;
   logic ram_we;
   logic [8:0] data_k;
   logic [15:0] cal_result_q;
   logic [15:0] command_q;
   logic [15:0] base_period_q;
   logic [15:0] ctrl_q;
   logic [15:0] num_pend_q;
   logic [15:0] den_pend_q;
   logic [15:0] num_act_q;
   logic [15:0] den_act_q;
   logic [15:0] press_raw_q;
   logic press_written_q;
   logic [15:0] press_act_q;
   logic press_act_vld_q;
   logic zero_cal_q;
   logic reg_we;
   logic [15:0] reg_waddr;
   logic [8:0] frame_len_wr;
   logic frame_ok;
   logic tx_ld;
   logic [7:0] pay_byte;
   logic [8:0] rd_off;
   logic [15:0] rd_word;

   // ==========================================================
   // CRC-16 byte update, reflected polynomial
   function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] data);
      logic [15:0] c;
      c = crc ^ {8'h00, data};
      for (int i = 0; i < 8; i++)
      begin
         c = c[0] ? ((c >> 1) ^ gscr_pkg::CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction

   // Unmapped addresses read as zero; reserved space stays harmless
   function automatic logic [15:0] reg_read(input logic [15:0] a, input logic [15:0] cal, input logic [15:0] cmd,
                                            input logic [15:0] per, input logic [15:0] ctl, input logic [15:0] num,
                                            input logic [15:0] den, input logic [15:0] prs);
      logic [15:0] v;
      v = 16'h0000;
      case (a)
         gscr_pkg::ADDR_CAL_RESULT: v = cal;
         gscr_pkg::ADDR_COMMAND: v = cmd;
         gscr_pkg::ADDR_BASE_PERIOD: v = per;
         gscr_pkg::ADDR_CTRL_WORD: v = ctl;
         gscr_pkg::ADDR_SCALE_NUM: v = num;
         gscr_pkg::ADDR_SCALE_DEN: v = den;
         gscr_pkg::ADDR_PRESSURE: v = prs;
         default: v = 16'h0000;
      endcase
      return v;
   endfunction

   // ==========================================================
   // Receive framing
   assign frame_len_wr = gscr_pkg::LEN_WRITE_HDR + 9'({1'b0, bc_q}) + 9'h002;
   // Residue of zero means the appended check matched
   assign frame_ok = (rx_cnt_q >= gscr_pkg::LEN_MIN) && (crc_rx_q == 16'h0000) && !rx_ovf_q
                     && (addr_q == DEV_ADDR);
   assign data_k = rx_cnt_q - gscr_pkg::LEN_WRITE_HDR;
   assign ram_we = (st_q == gscr_pkg::GSCR_ST_IDLE) && rx_valid && (func_q == gscr_pkg::FC_WRITE_MULTI)
                   && (rx_cnt_q >= gscr_pkg::LEN_WRITE_HDR) && (data_k < 9'({1'b0, bc_q}))
                   && (data_k < 9'(2 * WR_MAX)) && data_k[0];

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         rx_cnt_q <= '0;
         rx_ovf_q <= 1'b0;
         crc_rx_q <= gscr_pkg::CRC_INIT;
         addr_q <= 8'h00;
         func_q <= 8'h00;
         start_q <= 16'h0000;
         count_q <= 16'h0000;
         bc_q <= 8'h00;
         hi_byte_q <= 8'h00;
      end
      else if (rx_frame_end)
      begin
         rx_cnt_q <= '0;
         rx_ovf_q <= 1'b0;
      end
      else if (rx_valid && (st_q == gscr_pkg::GSCR_ST_IDLE))
      begin
         crc_rx_q <= crc16_byte((rx_cnt_q == 9'h000) ? gscr_pkg::CRC_INIT : crc_rx_q, rx_byte);
         if (rx_cnt_q == 9'h1ff)
         begin
            rx_ovf_q <= 1'b1;
         end
         else
         begin
            rx_cnt_q <= rx_cnt_q + 9'h001;
         end
         case (rx_cnt_q)
            9'h000: addr_q <= rx_byte;
            9'h001: func_q <= rx_byte;
            9'h002: start_q[15:8] <= rx_byte;
            9'h003: start_q[7:0] <= rx_byte;
            9'h004: count_q[15:8] <= rx_byte;
            9'h005: count_q[7:0] <= rx_byte;
            9'h006: bc_q <= rx_byte;
            default: hi_byte_q <= rx_byte;
         endcase
      end
   end

   gscr_ram #(
      .DW(16),
      .AW(RAM_AW)
   ) u_ram (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .wr_en(ram_we),
      .wr_addr(data_k[RAM_AW:1]),
      .wr_data({hi_byte_q, rx_byte}),
      .rd_addr(ap_idx_q),
      .rd_data(ram_rdata)
   );

   // ==========================================================
   // Sequencer: decide, apply staged writes, send reply
   assign tx_ld = (st_q == gscr_pkg::GSCR_ST_TX) && (!tx_valid_q || tx_ready);

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         st_q <= gscr_pkg::GSCR_ST_IDLE;
         kind_q <= gscr_pkg::GSCR_RK_EXC;
         exc_q <= 8'h00;
         plen_q <= '0;
         ap_idx_q <= '0;
         ap_widx_q <= '0;
         ap_vld_q <= 1'b0;
         ap_issue_done_q <= 1'b0;
      end
      else
      begin
         case (st_q)
            gscr_pkg::GSCR_ST_IDLE:
            begin
               ap_idx_q <= '0;
               ap_vld_q <= 1'b0;
               ap_issue_done_q <= 1'b0;
               if (rx_frame_end && frame_ok)
               begin
                  if (func_q == gscr_pkg::FC_READ_HOLD)
                  begin
                     if (rx_cnt_q == gscr_pkg::LEN_READ_REQ)
                     begin
                        st_q <= gscr_pkg::GSCR_ST_TX;
                        if ((count_q != 16'h0000) && (count_q <= gscr_pkg::READ_MAX))
                        begin
                           kind_q <= gscr_pkg::GSCR_RK_READ;
                           plen_q <= gscr_pkg::LEN_EXC_RSP + 9'({count_q[7:0], 1'b0});
                        end
                        else
                        begin
                           kind_q <= gscr_pkg::GSCR_RK_EXC;
                           exc_q <= gscr_pkg::EXC_BAD_VALUE;
                           plen_q <= gscr_pkg::LEN_EXC_RSP;
                        end
                     end
                  end
                  else if (func_q == gscr_pkg::FC_WRITE_MULTI)
                  begin
                     if (rx_cnt_q == frame_len_wr)
                     begin
                        if ((count_q != 16'h0000) && (count_q <= 16'(WR_MAX))
                            && ({8'h00, bc_q} == {count_q[14:0], 1'b0}))
                        begin
                           st_q <= gscr_pkg::GSCR_ST_APPLY;
                           kind_q <= gscr_pkg::GSCR_RK_WRITE;
                           plen_q <= gscr_pkg::LEN_WRITE_RSP;
                        end
                        else
                        begin
                           st_q <= gscr_pkg::GSCR_ST_TX;
                           kind_q <= gscr_pkg::GSCR_RK_EXC;
                           exc_q <= gscr_pkg::EXC_BAD_VALUE;
                           plen_q <= gscr_pkg::LEN_EXC_RSP;
                        end
                     end
                  end
                  else
                  begin
                     st_q <= gscr_pkg::GSCR_ST_TX;
                     kind_q <= gscr_pkg::GSCR_RK_EXC;
                     exc_q <= gscr_pkg::EXC_BAD_FUNC;
                     plen_q <= gscr_pkg::LEN_EXC_RSP;
                  end
               end
            end
            gscr_pkg::GSCR_ST_APPLY:
            begin
               // Memory read is registered, so the register write trails the address by one cycle
               ap_vld_q <= !ap_issue_done_q;
               ap_widx_q <= ap_idx_q;
               if (!ap_issue_done_q)
               begin
                  if ({9'h000, ap_idx_q} == 16'(count_q - 16'h0001))
                  begin
                     ap_issue_done_q <= 1'b1;
                  end
                  else
                  begin
                     ap_idx_q <= ap_idx_q + 1'b1;
                  end
               end
               else if (!ap_vld_q)
               begin
                  st_q <= gscr_pkg::GSCR_ST_TX;
               end
            end
            gscr_pkg::GSCR_ST_TX:
            begin
               if (tx_ld && (tx_idx_q == plen_q + 9'h002))
               begin
                  st_q <= gscr_pkg::GSCR_ST_IDLE;
               end
            end
            default: st_q <= gscr_pkg::GSCR_ST_IDLE;
         endcase
      end
   end

   assign reg_we = (st_q == gscr_pkg::GSCR_ST_APPLY) && ap_vld_q;
   assign reg_waddr = start_q + {9'h000, ap_widx_q};

   // ==========================================================
   // Reply byte generation
   assign rd_off = tx_idx_q - gscr_pkg::LEN_EXC_RSP;
   assign rd_word = reg_read(start_q + {8'h00, rd_off[8:1]}, cal_result_q, command_q, base_period_q, ctrl_q,
                             num_act_q, den_act_q, press_raw_q);

   always_comb
   begin
      pay_byte = 8'h00;
      if (tx_idx_q == 9'h000)
      begin
         pay_byte = DEV_ADDR;
      end
      else if (tx_idx_q == 9'h001)
      begin
         pay_byte = (kind_q == gscr_pkg::GSCR_RK_EXC) ? (func_q | gscr_pkg::FC_EXC_FLAG) : func_q;
      end
      else
      begin
         case (kind_q)
            gscr_pkg::GSCR_RK_EXC: pay_byte = exc_q;
            gscr_pkg::GSCR_RK_WRITE:
            begin
               case (tx_idx_q)
                  9'h002: pay_byte = start_q[15:8];
                  9'h003: pay_byte = start_q[7:0];
                  9'h004: pay_byte = count_q[15:8];
                  default: pay_byte = count_q[7:0];
               endcase
            end
            gscr_pkg::GSCR_RK_READ:
            begin
               if (tx_idx_q == 9'h002)
               begin
                  pay_byte = {count_q[6:0], 1'b0};
               end
               else
               begin
                  pay_byte = rd_off[0] ? rd_word[7:0] : rd_word[15:8];
               end
            end
            default: pay_byte = 8'h00;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         tx_idx_q <= '0;
         crc_tx_q <= gscr_pkg::CRC_INIT;
         tx_byte_q <= 8'h00;
         tx_valid_q <= 1'b0;
      end
      else if (st_q != gscr_pkg::GSCR_ST_TX)
      begin
         tx_idx_q <= '0;
         crc_tx_q <= gscr_pkg::CRC_INIT;
         tx_valid_q <= 1'b0;
      end
      else if (tx_ld)
      begin
         tx_idx_q <= tx_idx_q + 9'h001;
         tx_valid_q <= (tx_idx_q != plen_q + 9'h002);
         if (tx_idx_q < plen_q)
         begin
            tx_byte_q <= pay_byte;
            crc_tx_q <= crc16_byte(crc_tx_q, pay_byte);
         end
         else if (tx_idx_q == plen_q)
         begin
            tx_byte_q <= crc_tx_q[7:0];
         end
         else
         begin
            tx_byte_q <= crc_tx_q[15:8];
         end
      end
   end

   assign tx_byte = tx_byte_q;
   assign tx_valid = tx_valid_q;

   // ==========================================================
   // Holding registers
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         cal_result_q <= gscr_pkg::RST_CAL_RESULT;
         command_q <= gscr_pkg::RST_COMMAND;
         base_period_q <= gscr_pkg::RST_BASE_PERIOD;
         ctrl_q <= gscr_pkg::RST_CTRL_WORD;
         num_pend_q <= gscr_pkg::RST_SCALE_NUM;
         den_pend_q <= gscr_pkg::RST_SCALE_DEN;
         press_raw_q <= gscr_pkg::RST_PRESSURE;
         press_written_q <= 1'b0;
         zero_cal_q <= 1'b0;
      end
      else
      begin
         zero_cal_q <= reg_we && (reg_waddr == gscr_pkg::ADDR_COMMAND) && (ram_rdata == gscr_pkg::CMD_ZERO_CAL);
         if (reg_we)
         begin
            case (reg_waddr)
               gscr_pkg::ADDR_CAL_RESULT: cal_result_q <= ram_rdata;
               gscr_pkg::ADDR_COMMAND: command_q <= ram_rdata;
               gscr_pkg::ADDR_BASE_PERIOD: base_period_q <= ram_rdata;
               gscr_pkg::ADDR_CTRL_WORD: ctrl_q <= ram_rdata;
               gscr_pkg::ADDR_SCALE_NUM: num_pend_q <= ram_rdata;
               gscr_pkg::ADDR_SCALE_DEN: den_pend_q <= ram_rdata;
               gscr_pkg::ADDR_PRESSURE:
               begin
                  press_raw_q <= ram_rdata;
                  press_written_q <= 1'b1;
               end
               default: press_written_q <= press_written_q;
            endcase
         end
         // Calibration outcome wins over a client write in the same cycle
         if (cal_done)
         begin
            cal_result_q <= cal_ok ? gscr_pkg::CAL_OK : gscr_pkg::CAL_FAIL;
         end
      end
   end

   // Staged scaling only reaches the calculation and readback on sensor reset
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         num_act_q <= gscr_pkg::RST_SCALE_NUM;
         den_act_q <= gscr_pkg::RST_SCALE_DEN;
      end
      else if (sensor_reset)
      begin
         num_act_q <= num_pend_q;
         den_act_q <= den_pend_q;
      end
   end

   // Pressure sampled once per gas calculation, so a fresh write lags up to one period
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         press_act_q <= gscr_pkg::PRESS_MIN;
         press_act_vld_q <= 1'b0;
      end
      else if (meas_tick)
      begin
         press_act_vld_q <= press_written_q;
         if (press_raw_q < gscr_pkg::PRESS_MIN)
         begin
            press_act_q <= gscr_pkg::PRESS_MIN;
         end
         else if (press_raw_q > gscr_pkg::PRESS_MAX)
         begin
            press_act_q <= gscr_pkg::PRESS_MAX;
         end
         else
         begin
            press_act_q <= press_raw_q;
         end
      end
   end

   // ==========================================================
   // Measurement controls
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         abc_en <= 1'b0;
         iir_dyn_en <= 1'b0;
         iir_static_en <= 1'b0;
         pcomp_en <= 1'b0;
      end
      else
      begin
         abc_en <= !ctrl_q[gscr_pkg::CTRL_ABC_OFF_BIT] && (base_period_q != 16'h0000);
         iir_dyn_en <= (ctrl_q[gscr_pkg::CTRL_IIR_HI_BIT:gscr_pkg::CTRL_IIR_LO_BIT] == 2'b00);
         // Mixed bit settings leave only the static filter running
         iir_static_en <= (ctrl_q[gscr_pkg::CTRL_IIR_HI_BIT] ^ ctrl_q[gscr_pkg::CTRL_IIR_LO_BIT]);
         pcomp_en <= !ctrl_q[gscr_pkg::CTRL_PCOMP_OFF_BIT] && press_act_vld_q;
      end
   end

   assign zero_cal_start = zero_cal_q;
   assign abc_period = base_period_q;
   assign pcomp_pressure = press_act_q;
   assign scale_num = num_act_q;
   assign scale_den = den_act_q;
endmodule

// *** verification/gscr_client.sv ***
// Serial client model: frames requests with check code and collects replies
module gscr_client (
   input wire logic ref_clk,
   output logic [7:0] rx_byte,
   output logic rx_valid,
   output logic rx_frame_end,
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   output logic tx_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rsp[$];
   initial
   begin
      rx_byte = 8'h00;
      rx_valid = 1'b0;
      rx_frame_end = 1'b0;
      tx_ready = 1'b0;
   end
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = gscr_pkg::CRC_INIT;
      foreach (q[i])
      begin
         c = c ^ {8'h00, q[i]};
         repeat (8)
            c = c[0] ? (c >> 1) ^ gscr_pkg::CRC_POLY : c >> 1;
      end
      return c;
   endfunction
   // n is the reply length expected; bad spoils the check code on purpose
   task automatic xfer(input logic [7:0] q[$], input int n, input bit bad);
      logic [15:0] c;
      int k;
      c = crc16(q) ^ {15'h0000, bad};
      q.push_back(c[7:0]);
      q.push_back(c[15:8]);
      rsp.delete();
      foreach (q[i])
      begin
         @(negedge ref_clk);
         rx_byte = q[i];
         rx_valid = 1'b1;
      end
      @(negedge ref_clk);
      rx_valid = 1'b0;
      rx_byte = ~rx_byte;
      rx_frame_end = 1'b1;
      @(negedge ref_clk);
      rx_frame_end = 1'b0;
      k = 0;
      while (n == 0 ? k < 30 : rsp.size() < n && k < 600)
      begin
         tx_ready = 1'($urandom_range(0, 1));
         @(posedge ref_clk);
         if (tx_valid && tx_ready)
            rsp.push_back(tx_byte);
         @(negedge ref_clk);
         k++;
      end
      tx_ready = 1'b0;
      repeat (3) @(negedge ref_clk);
   endtask
endmodule

// *** verification/gscr_top_props.sv ***
// Port-level checks for the gas sensor register block
module gscr_top_props (
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic rx_frame_end,
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic meas_tick,
   input wire logic sensor_reset,
   input wire logic zero_cal_start,
   input wire logic abc_en,
   input wire logic [15:0] abc_period,
   input wire logic iir_dyn_en,
   input wire logic iir_static_en,
   input wire logic pcomp_en,
   input wire logic [15:0] pcomp_pressure,
   input wire logic [15:0] scale_num,
   input wire logic [15:0] scale_den
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);
   // ========================================
   // Age since last frame boundary, saturating so idle time cannot wrap
   logic [7:0] fe_age_q;
   always_ff @(posedge ref_clk)
   begin
      if (!rst_n || rx_frame_end)
         fe_age_q <= 8'h00;
      else if (fe_age_q != 8'hff)
         fe_age_q <= fe_age_q + 8'h01;
   end
   chk_abc_period_nz: assert property (abc_en |-> $past(abc_period) != 16'h0000) else $error("abc on, period 0");
   chk_iir_exclusive: assert property (!(iir_dyn_en && iir_static_en)) else $error("both filters on");
   chk_press_clamped: assert property (pcomp_pressure >= gscr_pkg::PRESS_MIN
      && pcomp_pressure <= gscr_pkg::PRESS_MAX) else $error("pressure out of range");
   chk_press_at_tick: assert property (!$past(meas_tick) && !$past(meas_tick, 2) && $past(rst_n, 2)
      |-> $stable(pcomp_pressure)) else $error("pressure moved off tick");
   chk_scale_at_reset: assert property (!$past(sensor_reset) && !$past(sensor_reset, 2) && $past(rst_n, 2)
      |-> $stable({scale_num, scale_den})) else $error("scale moved off reset");
   chk_cal_one_pulse: assert property (zero_cal_start |=> !zero_cal_start) else $error("cal start too long");
   chk_tx_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte)) else $error("tx dropped");
   chk_tx_after_frame: assert property ($rose(tx_valid) |-> fe_age_q < 8'd140) else $error("reply w/o frame");
   cov_cal: cover property (zero_cal_start);
   cov_pcomp: cover property ($rose(pcomp_en));
   cov_scale: cover property ($changed(scale_num));
   cov_stall: cover property (tx_valid && !tx_ready);
endmodule

bind gscr_top gscr_top_props u_props (.*);

// *** verification/testbench.sv ***
// Self-checking bench for the gas sensor register block
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, rst_n, meas_tick, sensor_reset, cal_done, cal_ok;
   logic [7:0] rx_byte, tx_byte;
   logic rx_valid, rx_frame_end, tx_valid, tx_ready, zero_cal_start, abc_en, iir_dyn_en, iir_static_en, pcomp_en;
   logic [15:0] abc_period, pcomp_pressure, scale_num, scale_den, w;
   int n_fail, total_checks, cycles, n_cal, st_num, st_den, prs_used, wrote, wrote_at_tick;
   int mem [64];
   int pv [5] = '{1000, 20000, 9970, 3000, 13000};
   gscr_top DUT (.*);
   gscr_client C (.*);
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      n_cal += (zero_cal_start === 1'b1);
      cycles++;
      if (cycles == 20000)
      begin
         n_fail++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks=%0d fails=%0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] v, input logic [31:0] e);
      total_checks++;
      if (v !== e)
      begin
         n_fail++;
         $display("MISMATCH t=%0t got %h exp %h", $time, v, e);
      end
   endtask
   task automatic outs();
      chk(abc_en, !mem[18][1] && mem[13] != 0);
      chk(abc_period, mem[13]);
      chk(iir_dyn_en, mem[18][3:2] == 2'b00);
      chk(iir_static_en, mem[18][3] != mem[18][2]);
      chk(pcomp_en, !mem[18][4] && wrote_at_tick);
      chk(pcomp_pressure, prs_used);
      chk({scale_num, scale_den}, {16'(mem[20]), 16'(mem[21])});
   endtask
   task automatic cmp(input logic [7:0] e[$]);
      logic [15:0] c;
      c = C.crc16(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
      chk(C.rsp.size(), e.size());
      foreach (e[i])
         if (i < C.rsp.size())
            chk(C.rsp[i], e[i]);
   endtask
   task automatic rd(input int a, input int n);
      logic [7:0] e[$];
      e = {8'h68, 8'h03, 8'(2 * n)};
      for (int i = 0; i < n; i++)
      begin
         e.push_back(8'(mem[a + i] >> 8));
         e.push_back(8'(mem[a + i]));
      end
      C.xfer({8'h68, 8'h03, 8'h00, 8'(a), 8'h00, 8'(n)}, 5 + 2 * n, 1'b0);
      cmp(e);
   endtask
   task automatic wr(input int a, input logic [15:0] d[$]);
      logic [7:0] q[$];
      q = {8'h68, 8'h10, 8'h00, 8'(a), 8'h00, 8'(d.size()), 8'(2 * d.size())};
      foreach (d[i])
      begin
         q.push_back(d[i][15:8]);
         q.push_back(d[i][7:0]);
         // Scaling is only staged; it goes live at the next sensor reset
         if (a + i == 20)
            st_num = d[i];
         else if (a + i == 21)
            st_den = d[i];
         else
            mem[a + i] = d[i];
         wrote |= (a + i == 46);
      end
      C.xfer(q, 8, 1'b0);
      cmp({8'h68, 8'h10, 8'h00, 8'(a), 8'h00, 8'(d.size())});
      outs();
   endtask
   task automatic tick();
      @(negedge ref_clk);
      meas_tick = 1'b1;
      @(negedge ref_clk);
      meas_tick = 1'b0;
      wrote_at_tick = wrote;
      prs_used = mem[46] < 3000 ? 3000 : mem[46] > 13000 ? 13000 : mem[46];
      repeat (2) @(negedge ref_clk);
      outs();
   endtask
   // ========================================
   // Main sequence
   initial
   begin
      {rst_n, meas_tick, sensor_reset, cal_done, cal_ok} = 5'h00;
      void'($urandom(61690));
      mem = '{default: 0};
      mem[13] = 1;
      mem[20] = 1;
      mem[21] = 1;
      prs_used = 3000;
      repeat (3) @(negedge ref_clk);
      rst_n = 1'b1;
      repeat (2) @(negedge ref_clk);
      outs();
      rd(0, 22);
      wr(13, {16'h0000});
      wr(13, {16'h00c8});
      wr(1, {gscr_pkg::CMD_ZERO_CAL});
      chk(n_cal, 1);
      for (int i = 1; i >= 0; i--)
      begin
         @(negedge ref_clk);
         cal_done = 1'b1;
         cal_ok = i[0];
         @(negedge ref_clk);
         cal_done = 1'b0;
         mem[0] = i ? 16'h0040 : 16'h0000;
         rd(0, 1);
      end
      tick();
      foreach (pv[i])
      begin
         wr(46, {16'(pv[i])});
         rd(46, 1);
         tick();
      end
      for (int i = 0; i < 16; i++)
      begin
         rd(18, 1);
         w = 16'($urandom) & 16'hffe1 | 16'(i << 1);
         wr(18, {w});
      end
      wr(20, {16'h22ef, 16'h1000});
      rd(20, 2);
      @(negedge ref_clk);
      sensor_reset = 1'b1;
      @(negedge ref_clk);
      sensor_reset = 1'b0;
      mem[20] = st_num;
      mem[21] = st_den;
      repeat (2) @(negedge ref_clk);
      rd(20, 2);
      outs();
      C.xfer({8'h68, 8'h03, 8'h00, 8'h12, 8'h00, 8'h01}, 0, 1'b1);
      chk(C.rsp.size(), 0);
      C.xfer({8'h68, 8'h06, 8'h00, 8'h12, 8'h00, 8'h01}, 5, 1'b0);
      cmp({8'h68, 8'h86, 8'h01});
      conclude();
   end
endmodule
